// [miop_params.svh]
// constants for the i/o port pin logic: port indices and widths
`ifndef MIOP_PARAMS_SVH
`define MIOP_PARAMS_SVH
`define MIOP_PORT_A 2'h0
`define MIOP_PORT_B 2'h1
`define MIOP_PORT_C 2'h2
`define MIOP_PORT_D 2'h3
`define MIOP_WA 8
`define MIOP_WB 8
`define MIOP_WC 4
`define MIOP_WD 2
`define MIOP_LANE_MASK 8'hff
`endif

// [miop_pkg.sv]
// types for the i/o port pin logic
package miop_pkg;
    typedef enum logic [1:0] {
        miop_reg_dir = 2'h0,
        miop_reg_drive = 2'h1,
        miop_reg_ctrl = 2'h2,
        miop_reg_dout = 2'h3
    } miop_reg_sel_t;

    typedef enum logic [2:0] {
        miop_rb_dir = 3'h0,
        miop_rb_drive = 3'h1,
        miop_rb_ctrl = 3'h2,
        miop_rb_dout = 3'h3,
        miop_rb_oe = 3'h4,
        miop_rb_pin = 3'h5
    } miop_rb_sel_t;

    typedef logic [3:0][7:0] miop_bank_t;

    typedef struct packed {
        miop_bank_t dir;
        miop_bank_t drv;
        miop_bank_t ctl;
        miop_bank_t dout;
        miop_bank_t pout;
        miop_bank_t poe;
        logic [7:0] rdata;
        logic omc_clk;
        logic auto_power_down;
        logic standby;
    } miop_state_t;
endpackage

// [miop_sync.sv]
// two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module miop_sync #(
    parameter int W = 22
) (
    input logic clock,
    input logic rst,
    input logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } miop_sync_state_t;

    miop_sync_state_t st_reg;
    miop_sync_state_t st_next;

    // first stage feeds only the second stage
    always_comb begin
        st_next = st_reg;
        st_next.s1 = d;
        st_next.s2 = st_reg.s1;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign q = st_reg.s2;
endmodule

// [miop_port_logic.sv]
// i/o port pin logic: per-pin registers, output mux, enable, readback, port d functions
`timescale 1ns/1ps
`include "miop_params.svh"
module miop_port_logic
    import miop_pkg::*;
#(
    parameter int WA = `MIOP_WA,
    parameter int WB = `MIOP_WB,
    parameter int WC = `MIOP_WC,
    parameter int WD = `MIOP_WD
) (
    // clock and reset
    input logic clock,
    input logic rst,
    // processor writes
    input logic cpu_wr,
    input miop_reg_sel_t cpu_wr_reg,
    input logic [1:0] cpu_wr_port,
    input logic [7:0] cpu_wdata,
    // processor readback
    input miop_rb_sel_t cpu_rd_src,
    input logic [1:0] cpu_rd_port,
    output logic [7:0] cpu_rdata,
    // build-time configuration
    input logic [WA-1:0] cfg_omc_a,
    input logic [WB-1:0] cfg_omc_b,
    input logic [WC-1:0] cfg_omc_c,
    input logic [WA-1:0] cfg_periph_a,
    input logic cfg_pd1_clk,
    input logic cfg_pd2_csi,
    // logic array and processor sources
    input logic [WA-1:0] omc_out_a,
    input logic [WB-1:0] omc_out_b,
    input logic [WC-1:0] omc_out_c,
    input logic [WA-1:0] pt_oe_a,
    input logic [WB-1:0] pt_oe_b,
    input logic [WC-1:0] pt_oe_c,
    input logic [WD-1:0] pt_oe_d,
    input logic [WA-1:0] periph_data_a,
    input logic [7:0] addr_lat_lo,
    input logic [7:0] addr_lat_hi,
    // port a pins
    input logic [WA-1:0] pin_a_in,
    output logic [WA-1:0] pin_a_out,
    output logic [WA-1:0] pin_a_oe,
    // port b pins
    input logic [WB-1:0] pin_b_in,
    output logic [WB-1:0] pin_b_out,
    output logic [WB-1:0] pin_b_oe,
    // port c pins
    input logic [WC-1:0] pin_c_in,
    output logic [WC-1:0] pin_c_out,
    output logic [WC-1:0] pin_c_oe,
    // port d pins
    input logic [WD-1:0] pin_d_in,
    output logic [WD-1:0] pin_d_out,
    output logic [WD-1:0] pin_d_oe,
    // input macrocell feeds
    output logic [WA-1:0] imc_a,
    output logic [WB-1:0] imc_b,
    output logic [WC-1:0] imc_c,
    output logic [WD-1:0] imc_d,
    // drive type and port d functions
    output logic [WA-1:0] drive_sel_a,
    output logic [WB-1:0] drive_sel_b,
    output logic [WC-1:0] drive_sel_c,
    output logic [WD-1:0] slew_fast_d,
    output logic omc_common_clk,
    output logic auto_power_down_in,
    output logic flash_standby
);
    localparam int WALL = WA + WB + WC + WD;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [7:0] port_mask(input logic [1:0] p);
        logic [7:0] m;
        m = 8'h00;
        case (p)
            `MIOP_PORT_A: m = 8'(`MIOP_LANE_MASK >> (8 - WA));
            `MIOP_PORT_B: m = 8'(`MIOP_LANE_MASK >> (8 - WB));
            `MIOP_PORT_C: m = 8'(`MIOP_LANE_MASK >> (8 - WC));
            default: m = 8'(`MIOP_LANE_MASK >> (8 - WD));
        endcase
        return m;
    endfunction

    // address mode beats peripheral, peripheral beats macrocell
    function automatic logic [7:0] out_mux(input logic [7:0] ctl, input logic [7:0] dout,
                                           input logic [7:0] addr, input logic [7:0] per,
                                           input logic [7:0] output_macrocell, input logic [7:0] use_per,
                                           input logic [7:0] use_omc);
        logic [7:0] o;
        o = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (ctl[i]) begin
                o[i] = addr[i];
            end else if (use_per[i]) begin
                o[i] = per[i];
            end else if (use_omc[i]) begin
                o[i] = output_macrocell[i];
            end else begin
                o[i] = dout[i];
            end
        end
        return o;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisation and source alignment

    logic [WALL-1:0] sync_vec;
    miop_bank_t pin_sync;
    miop_bank_t addr_v;
    miop_bank_t per_v;
    miop_bank_t omc_v;
    miop_bank_t use_per_v;
    miop_bank_t use_omc_v;
    miop_bank_t pt_v;
    miop_bank_t addr_cap;
    miop_state_t st_reg;
    miop_state_t st_next;

    miop_sync #(
        .W(WALL)
    ) u_sync (
        .clock(clock),
        .rst(rst),
        .d({pin_d_in, pin_c_in, pin_b_in, pin_a_in}),
        .q(sync_vec)
    );

    assign pin_sync[0] = 8'(sync_vec[WA-1:0]);
    assign pin_sync[1] = 8'(sync_vec[WA+WB-1:WA]);
    assign pin_sync[2] = 8'(sync_vec[WA+WB+WC-1:WA+WB]);
    assign pin_sync[3] = 8'(sync_vec[WALL-1:WA+WB+WC]);
    assign imc_a = sync_vec[WA-1:0];
    assign imc_b = sync_vec[WA+WB-1:WA];
    assign imc_c = sync_vec[WA+WB+WC-1:WA+WB];
    assign imc_d = sync_vec[WALL-1:WA+WB+WC];

    // address only on a and b, peripheral only on a, macrocell on a to c
    assign addr_v = {8'h00, 8'h00, addr_lat_hi, addr_lat_lo};
    assign addr_cap = {8'h00, 8'h00, `MIOP_LANE_MASK, `MIOP_LANE_MASK};
    assign per_v = {8'h00, 8'h00, 8'h00, 8'(periph_data_a)};
    assign use_per_v = {8'h00, 8'h00, 8'h00, 8'(cfg_periph_a)};
    assign omc_v = {8'h00, 8'(omc_out_c), 8'(omc_out_b), 8'(omc_out_a)};
    assign use_omc_v = {8'h00, 8'(cfg_omc_c), 8'(cfg_omc_b), 8'(cfg_omc_a)};
    assign pt_v = {8'(pt_oe_d), 8'(pt_oe_c), 8'(pt_oe_b), 8'(pt_oe_a)};

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        st_next = st_reg;
        if (cpu_wr) begin
            case (cpu_wr_reg)
                miop_reg_dir: st_next.dir[cpu_wr_port] = cpu_wdata & port_mask(cpu_wr_port);
                miop_reg_drive: st_next.drv[cpu_wr_port] = cpu_wdata & port_mask(cpu_wr_port);
                miop_reg_ctrl: st_next.ctl[cpu_wr_port] = cpu_wdata & port_mask(cpu_wr_port);
                default: st_next.dout[cpu_wr_port] = cpu_wdata & port_mask(cpu_wr_port);
            endcase
        end
        for (int p = 0; p < 4; p++) begin
            // every bit picks its own source
            st_next.pout[p] = out_mux(st_reg.ctl[p] & addr_cap[p], st_reg.dout[p], addr_v[p],
                                      per_v[p], omc_v[p], use_per_v[p], use_omc_v[p])
                              & port_mask(2'(p));
            st_next.poe[p] = (pt_v[p] | st_reg.dir[p]) & port_mask(2'(p));
        end
        // one source at a time onto the read path
        case (cpu_rd_src)
            miop_rb_dir: st_next.rdata = st_reg.dir[cpu_rd_port];
            miop_rb_drive: st_next.rdata = st_reg.drv[cpu_rd_port];
            miop_rb_ctrl: st_next.rdata = st_reg.ctl[cpu_rd_port];
            miop_rb_dout: st_next.rdata = st_reg.dout[cpu_rd_port];
            miop_rb_oe: st_next.rdata = st_reg.poe[cpu_rd_port];
            miop_rb_pin: st_next.rdata = pin_sync[cpu_rd_port] & port_mask(cpu_rd_port);
            default: st_next.rdata = 8'h00;
        endcase
        st_next.omc_clk = cfg_pd1_clk & pin_sync[3][0];
        st_next.auto_power_down = cfg_pd1_clk & pin_sync[3][0];
        // small package has no bit2, so standby is never forced there
        st_next.standby = cfg_pd2_csi & pin_sync[3][1] & (WD > 1);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign cpu_rdata = st_reg.rdata;
    assign pin_a_out = st_reg.pout[0][WA-1:0];
    assign pin_b_out = st_reg.pout[1][WB-1:0];
    assign pin_c_out = st_reg.pout[2][WC-1:0];
    assign pin_d_out = st_reg.pout[3][WD-1:0];
    assign pin_a_oe = st_reg.poe[0][WA-1:0];
    assign pin_b_oe = st_reg.poe[1][WB-1:0];
    assign pin_c_oe = st_reg.poe[2][WC-1:0];
    assign pin_d_oe = st_reg.poe[3][WD-1:0];
    assign drive_sel_a = st_reg.drv[0][WA-1:0];
    assign drive_sel_b = st_reg.drv[1][WB-1:0];
    assign drive_sel_c = st_reg.drv[2][WC-1:0];
    assign slew_fast_d = st_reg.drv[3][WD-1:0];
    assign omc_common_clk = st_reg.omc_clk;
    assign auto_power_down_in = st_reg.auto_power_down;
    assign flash_standby = st_reg.standby;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence wr_dir_a_s;
        cpu_wr && cpu_wr_reg == miop_reg_dir && cpu_wr_port == `MIOP_PORT_A;
    endsequence

    sequence rd_dir_a_s;
        !cpu_wr && cpu_rd_src == miop_rb_dir && cpu_rd_port == `MIOP_PORT_A;
    endsequence

    dir_readback_a: assert property (wr_dir_a_s ##1 rd_dir_a_s |=>
        cpu_rdata == $past(cpu_wdata, 2)) else $error("direction readback mismatch");
    port_width_c_a: assert property (cpu_rd_src == miop_rb_dir && cpu_rd_port == `MIOP_PORT_C
        |=> cpu_rdata[7:4] == 4'h0) else $error("port c upper bits not zero");
    pin_independ_a: assert property (cpu_wr && cpu_wr_port == `MIOP_PORT_B |=>
        $stable(st_reg.dir[0]) && $stable(st_reg.dout[0]))
        else $error("write to b changed a");
    addr_mux_a: assert property (!$past(rst) && $past(st_reg.ctl[0][0]) |->
        pin_a_out[0] == $past(addr_lat_lo[0])) else $error("address not on pin a0");
    omc_mux_c_a: assert property (!$past(rst) && $past(cfg_omc_c[0]) |->
        pin_c_out[0] == $past(omc_out_c[0])) else $error("macrocell not on pin c0");
    readback_pin_a: assert property (cpu_rd_src == miop_rb_pin && cpu_rd_port == `MIOP_PORT_C
        |=> cpu_rdata == 8'($past(imc_c))) else $error("pin readback mismatch");
    readback_oe_a: assert property (cpu_rd_src == miop_rb_oe && cpu_rd_port == `MIOP_PORT_A
        |=> cpu_rdata == 8'($past(pin_a_oe))) else $error("enable readback mismatch");
    oe_or_gate_a: assert property (!$past(rst) |->
        pin_a_oe == $past(pt_oe_a | st_reg.dir[0][WA-1:0]))
        else $error("pin a enable not or of terms");
    oe_dir_only_a: assert property (!$past(rst) && $past(pt_oe_b) == '0 |->
        pin_b_oe == $past(st_reg.dir[1][WB-1:0])) else $error("direction not sole enable");
    sync_delay_a: assert property (!$past(rst) && !$past(rst, 2) |->
        imc_a == $past(pin_a_in, 2)) else $error("input macrocell path not two stages");
    pd1_clock_a: assert property (!$past(rst) |->
        omc_common_clk == $past(cfg_pd1_clk && pin_sync[3][0]) &&
        auto_power_down_in == omc_common_clk) else $error("bit1 clock path wrong");
    csi_standby_a: assert property (!$past(rst) |->
        flash_standby == $past(cfg_pd2_csi && pin_sync[3][1] && WD > 1))
        else $error("standby not forced by chip select");
    slew_write_a: assert property (cpu_wr && cpu_wr_reg == miop_reg_drive &&
        cpu_wr_port == `MIOP_PORT_D |=> slew_fast_d == $past(cpu_wdata[WD-1:0]))
        else $error("fast slew select not taken");
    sync_readback_a: assert property (!$past(rst) && !$past(rst, 2) && cpu_rd_src == miop_rb_pin &&
        cpu_rd_port == `MIOP_PORT_A |=> cpu_rdata == $past(pin_a_in, 3))
        else $error("pin readback not synchronised");
endmodule

// [miop_pin_model.sv]
// board-side model of the port pins: resolves each wire from driver enable and board source
`timescale 1ns/1ps
module miop_pin_model (
    // device drivers
    input logic [7:0] pin_a_out,
    input logic [7:0] pin_a_oe,
    input logic [7:0] pin_b_out,
    input logic [7:0] pin_b_oe,
    input logic [3:0] pin_c_out,
    input logic [3:0] pin_c_oe,
    input logic [1:0] pin_d_out,
    input logic [1:0] pin_d_oe,
    // board sources
    input logic [7:0] ext_a,
    input logic [7:0] ext_b,
    input logic [3:0] ext_c,
    input logic [1:0] ext_d,
    // wire levels seen by the device
    output logic [7:0] pin_a_in,
    output logic [7:0] pin_b_in,
    output logic [3:0] pin_c_in,
    output logic [1:0] pin_d_in
);
    // an enabled driver wins; a released bit shows the board source, never the last drive
    assign pin_a_in = (pin_a_oe & pin_a_out) | (~pin_a_oe & ext_a);
    assign pin_b_in = (pin_b_oe & pin_b_out) | (~pin_b_oe & ext_b);
    assign pin_c_in = (pin_c_oe & pin_c_out) | (~pin_c_oe & ext_c);
    assign pin_d_in = (pin_d_oe & pin_d_out) | (~pin_d_oe & ext_d);
endmodule

// [test_miop_port_logic.sv]
// self-checking testbench for the i/o port pin logic
`timescale 1ns/1ps
module test_miop_port_logic;
    import miop_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic cpu_wr = 1'b0;
    miop_reg_sel_t cpu_wr_reg = miop_reg_dir;
    miop_rb_sel_t cpu_rd_src = miop_rb_dir;
    logic [1:0] cpu_wr_port = 2'h0, cpu_rd_port = 2'h0;
    logic [7:0] cpu_wdata = 8'h00, cpu_rdata;
    logic [7:0] cfg_omc_a = 8'h00, cfg_omc_b = 8'h00, cfg_periph_a = 8'h00;
    logic [3:0] cfg_omc_c = 4'h0;
    logic cfg_pd1_clk = 1'b0, cfg_pd2_csi = 1'b0;
    logic [7:0] omc_out_a = 8'h00, omc_out_b = 8'h00, periph_data_a = 8'h00;
    logic [3:0] omc_out_c = 4'h0, pt_oe_c = 4'h0;
    logic [7:0] pt_oe_a = 8'h00, pt_oe_b = 8'h00, addr_lat_lo = 8'h00, addr_lat_hi = 8'h3c;
    logic [1:0] pt_oe_d = 2'h0;
    logic [7:0] ext_a = 8'h00, ext_b = 8'h00;
    logic [3:0] ext_c = 4'h0;
    logic [1:0] ext_d = 2'h0;
    logic [7:0] pin_a_in, pin_a_out, pin_a_oe, pin_b_in, pin_b_out, pin_b_oe, imc_a, imc_b;
    logic [3:0] pin_c_in, pin_c_out, pin_c_oe, imc_c;
    logic [1:0] pin_d_in, pin_d_out, pin_d_oe, imc_d, slew_fast_d;
    logic [7:0] drive_sel_a, drive_sel_b;
    logic [3:0] drive_sel_c;
    logic omc_common_clk, auto_power_down_in, flash_standby;
    int bad_count = 0;
    int n_tests = 0;
    int cycles = 0;

    miop_port_logic uut (.clock(clock), .rst(rst), .cpu_wr(cpu_wr), .cpu_wr_reg(cpu_wr_reg),
        .cpu_wr_port(cpu_wr_port), .cpu_wdata(cpu_wdata), .cpu_rd_src(cpu_rd_src),
        .cpu_rd_port(cpu_rd_port), .cpu_rdata(cpu_rdata), .cfg_omc_a(cfg_omc_a),
        .cfg_omc_b(cfg_omc_b), .cfg_omc_c(cfg_omc_c), .cfg_periph_a(cfg_periph_a),
        .cfg_pd1_clk(cfg_pd1_clk), .cfg_pd2_csi(cfg_pd2_csi), .omc_out_a(omc_out_a),
        .omc_out_b(omc_out_b), .omc_out_c(omc_out_c), .pt_oe_a(pt_oe_a), .pt_oe_b(pt_oe_b),
        .pt_oe_c(pt_oe_c), .pt_oe_d(pt_oe_d), .periph_data_a(periph_data_a),
        .addr_lat_lo(addr_lat_lo), .addr_lat_hi(addr_lat_hi), .pin_a_in(pin_a_in),
        .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe), .pin_b_in(pin_b_in), .pin_b_out(pin_b_out),
        .pin_b_oe(pin_b_oe), .pin_c_in(pin_c_in), .pin_c_out(pin_c_out), .pin_c_oe(pin_c_oe),
        .pin_d_in(pin_d_in), .pin_d_out(pin_d_out), .pin_d_oe(pin_d_oe), .imc_a(imc_a),
        .imc_b(imc_b), .imc_c(imc_c), .imc_d(imc_d), .drive_sel_a(drive_sel_a),
        .drive_sel_b(drive_sel_b), .drive_sel_c(drive_sel_c), .slew_fast_d(slew_fast_d),
        .omc_common_clk(omc_common_clk), .auto_power_down_in(auto_power_down_in),
        .flash_standby(flash_standby));

    miop_pin_model board (.pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe), .pin_b_out(pin_b_out),
        .pin_b_oe(pin_b_oe), .pin_c_out(pin_c_out), .pin_c_oe(pin_c_oe), .pin_d_out(pin_d_out),
        .pin_d_oe(pin_d_oe), .ext_a(ext_a), .ext_b(ext_b), .ext_c(ext_c), .ext_d(ext_d),
        .pin_a_in(pin_a_in), .pin_b_in(pin_b_in), .pin_c_in(pin_c_in), .pin_d_in(pin_d_in));

    always #12.5 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("comparisons=%0d mismatches=%0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // settle: lets pin and synchroniser latency pass, then samples off the edge
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic wr(input miop_reg_sel_t r, input logic [1:0] p, input logic [7:0] d);
        @(posedge clock);
        cpu_wr <= 1'b1;
        cpu_wr_reg <= r;
        cpu_wr_port <= p;
        cpu_wdata <= d;
        @(posedge clock);
        cpu_wr <= 1'b0;
    endtask

    task automatic rd(input miop_rb_sel_t s, input logic [1:0] p, input logic [7:0] exp);
        @(posedge clock);
        cpu_rd_src <= s;
        cpu_rd_port <= p;
        settle(1);
        chk(cpu_rdata, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            bad_count = bad_count + 1;
            end_of_test();
        end
    end

    initial begin
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        settle(1);
        chk(pin_a_oe, 8'h00);
        rd(miop_rb_dir, 2'h0, 8'h00);
        wr(miop_reg_dir, 2'h0, 8'hff);
        settle(2);
        chk(pin_a_oe, 8'hff);
        rd(miop_rb_dir, 2'h0, 8'hff);
        rd(miop_rb_oe, 2'h0, 8'hff);
        @(posedge clock);
        pt_oe_b <= 8'h0f;
        wr(miop_reg_dir, 2'h1, 8'h30);
        settle(2);
        chk(pin_b_oe, 8'h3f);
        rd(miop_rb_oe, 2'h1, 8'h3f);
        wr(miop_reg_dir, 2'h1, 8'h00);
        @(posedge clock);
        pt_oe_b <= 8'h00;
        settle(2);
        chk(pin_b_oe, 8'h00);
        wr(miop_reg_dout, 2'h0, 8'ha5);
        settle(2);
        chk(pin_a_out, 8'ha5);
        rd(miop_rb_dout, 2'h0, 8'ha5);
        // per-pin source mix on one port: periph on 5:4, macrocell on 3:0, data out above
        @(posedge clock);
        omc_out_a <= 8'hff;
        cfg_omc_a <= 8'h0f;
        cfg_periph_a <= 8'h30;
        settle(2);
        chk(pin_a_out, 8'h8f);
        wr(miop_reg_ctrl, 2'h0, 8'h01);
        settle(2);
        chk(pin_a_out, 8'h8e);
        rd(miop_rb_ctrl, 2'h0, 8'h01);
        wr(miop_reg_ctrl, 2'h1, 8'hff);
        settle(2);
        chk(pin_b_out, 8'h3c);
        wr(miop_reg_dout, 2'h2, 8'hff);
        rd(miop_rb_dout, 2'h2, 8'h0f);
        @(posedge clock);
        cfg_omc_c <= 4'h3;
        wr(miop_reg_ctrl, 2'h2, 8'hff);
        settle(2);
        chk({4'h0, pin_c_out}, 8'h0c);
        @(posedge clock);
        ext_c <= 4'h5;
        settle(4);
        rd(miop_rb_pin, 2'h2, 8'h05);
        chk({4'h0, imc_c}, 8'h05);
        rd(miop_rb_pin, 2'h0, 8'h8e);
        for (int k = 6; k < 8; k++) begin
            rd(miop_rb_sel_t'(k[2:0]), 2'h0, 8'h00);
        end
        wr(miop_reg_drive, 2'h0, 8'h5a);
        settle(2);
        chk(drive_sel_a, 8'h5a);
        @(posedge clock);
        cfg_pd1_clk <= 1'b1;
        ext_d <= 2'h1;
        settle(4);
        chk({6'h00, omc_common_clk, auto_power_down_in}, 8'h03);
        @(posedge clock);
        cfg_pd2_csi <= 1'b1;
        ext_d <= 2'h2;
        settle(4);
        chk({6'h00, flash_standby, omc_common_clk}, 8'h02);
        wr(miop_reg_drive, 2'h3, 8'h03);
        settle(2);
        chk({6'h00, slew_fast_d}, 8'h03);
        rd(miop_rb_drive, 2'h3, 8'h03);
        // write then read on the very next cycle
        @(posedge clock);
        cpu_rd_src <= miop_rb_dir;
        cpu_rd_port <= 2'h0;
        wr(miop_reg_dir, 2'h0, 8'hc3);
        settle(2);
        chk(cpu_rdata, 8'hc3);
        chk(pin_a_oe, 8'hc3);
        wr(miop_reg_drive, 2'h1, 8'h77);
        wr(miop_reg_drive, 2'h2, 8'hfa);
        wr(miop_reg_dir, 2'h3, 8'hff);
        wr(miop_reg_dout, 2'h3, 8'h01);
        ext_b <= 8'h69;
        settle(4);
        chk(drive_sel_b, 8'h77);
        chk({4'h0, drive_sel_c}, 8'h0a);
        chk({4'h0, pin_d_oe, pin_d_out}, 8'h0d);
        chk({6'h00, imc_d}, 8'h01);
        chk(imc_b, 8'h69);
        end_of_test();
    end
endmodule
